/* File: hbp_pkg.sv */
// Constants, encodings and AHB register map for the host bus port.
// Contract
// R01: Master drives select pins naming channel.
// R02: Request bus, start cycles only after grant.
// R03: Put 32-bit DMA address on AD pins.
// R04: Low half by strobe, high by upper strobe.
// R05: Strobes are inputs as slave, outputs mastering.
// R06: No strobe before config write: non-multiplexed.
// R07: Any strobe before config selects multiplexed.
// R08: Channel select low at config: ready style.
// R09: Value C0H: swap on, polarity, status ack.
// R10: Reset default is left-shift address decoding.
// R11: Core/channel select choose DMA, A or B.
// R12: Double pulse: ignore first, vector on second.
// R13: Single pulse: vector on the one pulse.
// R14: DMA moves single bytes, lane by A0.
// R15: Glue derives byte strobes from data strobe.
// R16: Glue disables select drivers during grant.
// R17: Reset input is active low.
// R18: Ready mode acknowledges data and vector accesses.
// R19: Host writes config first, only once.
// R20: Config bits 2:1 choose acknowledge type.
// R21: Bit 7 enables swap, bit 6 lane sense.
// R22: Release driven pins before dropping request.
// R23: Vector drive only in ack or read.
package hbp_pkg;
    // AHB register byte offsets
    localparam logic [7:0] HBP_OFS_CTRL = 8'h00;
    localparam logic [7:0] HBP_OFS_ADDR = 8'h04;
    localparam logic [7:0] HBP_OFS_WDATA = 8'h08;
    localparam logic [7:0] HBP_OFS_RDATA = 8'h0C;
    localparam logic [7:0] HBP_OFS_STAT = 8'h10;
    localparam logic [7:0] HBP_OFS_VEC = 8'h14;
    localparam logic [7:0] HBP_OFS_SLV = 8'h18;
    localparam logic [7:0] HBP_OFS_SRD = 8'h1C;
    // Control register fields
    localparam int HBP_CTRL_START = 0;
    localparam int HBP_CTRL_DIR = 1;
    localparam int HBP_CTRL_CH_LO = 2;
    // Config register fields
    localparam int HBP_CFG_SHIFT = 0;
    localparam int HBP_CFG_ACK_LO = 1;
    localparam int HBP_CFG_LANE = 6;
    localparam int HBP_CFG_SWAP = 7;
    localparam logic [7:0] HBP_CFG_RST = 8'h00;
    localparam logic [7:0] HBP_VEC_RST = 8'h00;
    // Acknowledge types from config bits 2:1
    localparam logic [1:0] HBP_ACK_STATUS = 2'h0;
    localparam logic [1:0] HBP_ACK_SINGLE = 2'h1;
    localparam logic [1:0] HBP_ACK_DOUBLE = 2'h3;
    // Slave targets
    localparam logic [1:0] HBP_TGT_DMA = 2'h0;
    localparam logic [1:0] HBP_TGT_CHB = 2'h2;
    localparam logic [1:0] HBP_TGT_CHA = 2'h3;
    // Cycles per address phase of a master transfer
    localparam logic [3:0] HBP_PH_CYC = 4'h3;
    // Master sequencer states
    typedef enum logic [2:0] {
        HBP_IDLE = 3'b000,
        HBP_REQ = 3'b001,
        HBP_ALO = 3'b010,
        HBP_AHI = 3'b011,
        HBP_DATA = 3'b100,
        HBP_REL = 3'b101
    } hbp_state_t;
endpackage

/* File: hbp_sync.sv */
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
`default_nettype none
module hbp_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '1
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Pin side and synced side
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    // Both stages held in one state word
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stab;
    } hbp_sync_t;
    hbp_sync_t s_q, s_d;

    // First stage only feeds the second
    always_comb begin
        s_d.meta = din;
        s_d.stab = s_q.meta;
    end

    // Idle pin level on reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= {RST_VAL, RST_VAL};
        end else begin
            s_q <= s_d;
        end
    end

    assign dout = s_q.stab;
endmodule
`default_nettype wire

/* File: hbp_port.sv */
// Host bus port: slave to the host pins, DMA bus master, AHB-Lite registers.
//
// Our own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module hbp_port
    import hbp_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Host control pins, sampled
    input wire logic ce_n,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic ds_n_in,
    input wire logic rw_in,
    input wire logic irq_ack_in_n,
    input wire logic bus_grant_in_n,
    // Two-way strobes and selects
    input wire logic addr_latch_strobe_n_in,
    input wire logic core_select_pin_in,
    input wire logic channel_select_pin_in,
    input wire logic wait_ready_in,
    input wire logic [15:0] ad_in,
    output logic rd_n_out,
    output logic wr_n_out,
    output logic ds_n_out,
    output logic rw_out,
    output logic addr_latch_strobe_n_out,
    output logic upper_addr_strobe_n,
    output logic ctl_oe_n,
    output logic core_select_pin_out,
    output logic channel_select_pin_out,
    output logic sel_oe_n,
    output logic wait_ready_out,
    output logic wait_ready_oe_n,
    output logic [15:0] ad_out,
    output logic ad_oe_n,
    // Arbitration
    output logic bus_request_out_n
);
    // Synced pin inputs
    logic [26:0] pin_s;
    logic ce_s, rd_s, wr_s, ds_s, rw_s, ack_s, gnt_s, as_s;
    logic cs_s, ch_s, wrdy_s;
    logic [15:0] ad_s;

    // Every pin passes two flops before use
    hbp_sync #(.WIDTH(27), .RST_VAL(27'h7FF_FFFF)) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .din({ce_n, rd_n_in, wr_n_in, ds_n_in, rw_in, irq_ack_in_n,
              bus_grant_in_n, addr_latch_strobe_n_in, core_select_pin_in,
              channel_select_pin_in, wait_ready_in, ad_in}),
        .dout(pin_s)
    );
    assign {ce_s, rd_s, wr_s, ds_s, rw_s, ack_s, gnt_s, as_s, cs_s,
            ch_s, wrdy_s, ad_s} = pin_s;

    // Whole module state
    typedef struct packed {
        hbp_state_t st;
        logic [3:0] tcnt;
        logic configured;
        logic muxed;
        logic as_seen;
        logic ready_mode;
        logic [7:0] cfg;
        logic [31:0] dma_addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic dir;
        logic [1:0] chan;
        logic done;
        logic [7:0] vector;
        logic [7:0] srd;
        logic [15:0] sinfo;
        logic [4:0] idx;
        logic prev_str;
        logic prev_as;
        logic prev_ack;
        logic ack_cnt;
        logic slv_drv;
        logic vec_drv;
        logic ap_wr;
        logic [7:0] ap_addr;
        logic [31:0] hrdata;
        logic [15:0] ad_out;
        logic ad_oe_n;
        logic as_n;
        logic uas_n;
        logic ds_n;
        logic rd_n;
        logic wr_n;
        logic ctl_oe_n;
        logic sel_oe_n;
        logic wrdy_o;
        logic wrdy_oe_n;
        logic req_n;
    } hbp_port_t;
    hbp_port_t s_q, s_d;

    // Slave target from core and channel selects
    function automatic logic [1:0] tgt_of(input logic cs, input logic ch);
        // Core low picks DMA, else channel A or B
        if (!cs) begin
            tgt_of = HBP_TGT_DMA;
        end else if (ch) begin
            tgt_of = HBP_TGT_CHA;
        end else begin
            tgt_of = HBP_TGT_CHB;
        end
    endfunction

    // Register index from AD lines per shift mode
    // R10 cfg bit0 clear at reset: left shift
    function automatic logic [4:0] idx_of(input logic [15:0] ad,
                                          input logic right);
        idx_of = right ? ad[4:0] : ad[5:1];
    endfunction

    // Helper terms
    logic strobe, hwr, str_rise, str_fall, ack_on, ack_off;
    logic [1:0] ack_type;
    logic take, done_ph, upper_lane;
    logic [31:0] rd_mux;

    always_comb begin
        strobe = !ce_s && (!rd_s || !wr_s || !ds_s);
        hwr = !wr_s || (!ds_s && !rw_s);
        str_rise = strobe && !s_q.prev_str;
        str_fall = !strobe && s_q.prev_str;
        ack_on = !ack_s && s_q.prev_ack;
        ack_off = ack_s && !s_q.prev_ack;
        ack_type = s_q.cfg[HBP_CFG_ACK_LO +: 2];
        take = hsel && hready && htrans[1];
        // Byte lane of a DMA read
        upper_lane = s_q.cfg[HBP_CFG_SWAP] &&
                     (s_q.dma_addr[0] == s_q.cfg[HBP_CFG_LANE]);
        // Ready mode waits for ready low, wait mode for wait released
        done_ph = (s_q.tcnt >= HBP_PH_CYC - 4'h1) &&
                  (s_q.ready_mode ? !wrdy_s : wrdy_s);
    end

    // Read data chosen at the address phase
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (haddr == HBP_OFS_CTRL) begin
            rd_mux = {28'h000_0000, s_q.chan, s_q.dir, 1'b0};
        end else if (haddr == HBP_OFS_ADDR) begin
            rd_mux = s_q.dma_addr;
        end else if (haddr == HBP_OFS_WDATA) begin
            rd_mux = {24'h00_0000, s_q.wdata};
        end else if (haddr == HBP_OFS_RDATA) begin
            rd_mux = {24'h00_0000, s_q.rdata};
        end else if (haddr == HBP_OFS_STAT) begin
            rd_mux = {16'h0000, s_q.cfg, 3'h0, s_q.done,
                      s_q.ready_mode, s_q.configured, s_q.muxed,
                      (s_q.st != HBP_IDLE)};
        end else if (haddr == HBP_OFS_VEC) begin
            rd_mux = {24'h00_0000, s_q.vector};
        end else if (haddr == HBP_OFS_SLV) begin
            rd_mux = {16'h0000, s_q.sinfo};
        end else if (haddr == HBP_OFS_SRD) begin
            rd_mux = {24'h00_0000, s_q.srd};
        end
    end

    // Next state of everything
    always_comb begin
        s_d = s_q;
        s_d.prev_str = strobe;
        s_d.prev_as = as_s;
        s_d.prev_ack = ack_s;
        // AHB address phase capture
        s_d.ap_wr = take && hwrite;
        s_d.ap_addr = haddr;
        if (take && !hwrite) begin
            s_d.hrdata = rd_mux;
        end
        // AHB data phase writes
        if (s_q.ap_wr) begin
            if (s_q.ap_addr == HBP_OFS_CTRL) begin
                s_d.dir = hwdata[HBP_CTRL_DIR];
                s_d.chan = hwdata[HBP_CTRL_CH_LO +: 2];
                if (hwdata[HBP_CTRL_START] && s_q.st == HBP_IDLE) begin
                    s_d.st = HBP_REQ;
                    s_d.done = 1'b0;
                end
            end else if (s_q.ap_addr == HBP_OFS_ADDR) begin
                s_d.dma_addr = hwdata;
            end else if (s_q.ap_addr == HBP_OFS_WDATA) begin
                s_d.wdata = hwdata[7:0];
            end else if (s_q.ap_addr == HBP_OFS_VEC) begin
                s_d.vector = hwdata[7:0];
            end else if (s_q.ap_addr == HBP_OFS_SRD) begin
                s_d.srd = hwdata[7:0];
            end
        end
        // R07 strobe before config, chip enable ignored
        if (!s_q.configured && !as_s && s_q.prev_as) begin
            s_d.as_seen = 1'b1;
        end
        // Multiplexed mode latches index on strobe release
        if (s_q.muxed && as_s && !s_q.prev_as && s_q.st == HBP_IDLE) begin
            s_d.idx = idx_of(ad_s, s_q.cfg[HBP_CFG_SHIFT]);
        end
        // Slave read starts driving register data, or the vector when ack is low under status acknowledge
        if (str_rise && !hwr && s_q.st == HBP_IDLE) begin
            if (!ack_s && ack_type == HBP_ACK_STATUS) begin
                s_d.vec_drv = 1'b1;
            end else begin
                s_d.slv_drv = 1'b1;
            end
        end
        // Slave write completes at strobe end
        if (str_fall) begin
            s_d.slv_drv = 1'b0;
            if (ack_type == HBP_ACK_STATUS) begin
                s_d.vec_drv = 1'b0;
            end
            if (s_q.sinfo[7]) begin
                if (!s_q.configured && !cs_s) begin
                    // R06 mode from earlier strobe only
                    s_d.configured = 1'b1;
                    s_d.muxed = s_q.as_seen;
                    // R08 channel select low picks ready
                    s_d.ready_mode = !ch_s;
                    // R09 value sets swap, lane and ack type
                    s_d.cfg = ad_s[7:0];
                end
                s_d.sinfo[15:8] = ad_s[7:0];
            end
        end
        // R11 record target and index of each access
        if (str_rise) begin
            s_d.sinfo[7] = hwr;
            s_d.sinfo[6:5] = tgt_of(cs_s, ch_s);
            s_d.sinfo[4:0] = s_q.idx;
        end
        // R20 pulsed acknowledge types
        if (ack_on && ack_type == HBP_ACK_SINGLE) begin
            // R13 vector on the one pulse
            s_d.vec_drv = 1'b1;
        end else if (ack_on && ack_type == HBP_ACK_DOUBLE) begin
            // R12 first pulse only counted
            s_d.ack_cnt = !s_q.ack_cnt;
            s_d.vec_drv = s_q.ack_cnt;
        end
        if (ack_off && ack_type != HBP_ACK_STATUS) begin
            s_d.vec_drv = 1'b0;
        end
        // Master sequencer
        s_d.tcnt = s_q.tcnt + 4'h1;
        case (s_q.st)
            HBP_IDLE: begin
                s_d.tcnt = 4'h0;
            end
            HBP_REQ: begin
                // R02 start only after grant
                s_d.tcnt = 4'h0;
                if (!gnt_s) begin
                    s_d.st = HBP_ALO;
                    s_d.slv_drv = 1'b0;
                    s_d.vec_drv = 1'b0;
                end
            end
            HBP_ALO: begin
                if (s_q.tcnt == HBP_PH_CYC - 4'h1) begin
                    s_d.st = HBP_AHI;
                    s_d.tcnt = 4'h0;
                end
            end
            HBP_AHI: begin
                if (s_q.tcnt == HBP_PH_CYC - 4'h1) begin
                    s_d.st = HBP_DATA;
                    s_d.tcnt = 4'h0;
                end
            end
            HBP_DATA: begin
                if (done_ph) begin
                    // R21 read lane from swap controls
                    if (!s_q.dir) begin
                        s_d.rdata = upper_lane ? ad_s[15:8] : ad_s[7:0];
                    end
                    s_d.st = HBP_REL;
                end
            end
            HBP_REL: begin
                s_d.st = HBP_IDLE;
                s_d.done = 1'b1;
            end
            default: begin
                s_d.st = HBP_IDLE;
            end
        endcase
        // Pin outputs from next state, so they come from flops
        s_d.req_n = !(s_d.st != HBP_IDLE);
        // R05 R22 drive only inside the owned window
        s_d.ctl_oe_n = !(s_d.st inside {HBP_ALO, HBP_AHI, HBP_DATA});
        s_d.sel_oe_n = s_d.ctl_oe_n;
        // R04 each half qualified by its own strobe
        s_d.as_n = !(s_d.st == HBP_ALO && s_d.tcnt != HBP_PH_CYC - 4'h1);
        s_d.uas_n = !(s_d.st == HBP_AHI && s_d.tcnt != HBP_PH_CYC - 4'h1);
        s_d.ds_n = !(s_d.st == HBP_DATA);
        s_d.rd_n = !(s_d.st == HBP_DATA && !s_d.dir);
        s_d.wr_n = !(s_d.st == HBP_DATA && s_d.dir);
        // R03 address halves, then write byte
        if (s_d.st == HBP_ALO) begin
            s_d.ad_out = s_d.dma_addr[15:0];
        end else if (s_d.st == HBP_AHI) begin
            s_d.ad_out = s_d.dma_addr[31:16];
        end else if (s_d.st == HBP_DATA) begin
            // R14 single byte on both lanes
            s_d.ad_out = {s_d.wdata, s_d.wdata};
        end else if (s_d.vec_drv) begin
            s_d.ad_out = {s_d.vector, s_d.vector};
        end else begin
            s_d.ad_out = {s_d.srd, s_d.srd};
        end
        // R23 vector or data only in ack or read
        s_d.ad_oe_n = !((s_d.ctl_oe_n == 1'b0 && !(s_d.st == HBP_DATA &&
                         !s_d.dir)) || s_d.vec_drv || s_d.slv_drv);
        // R18 acknowledge data and vector accesses
        s_d.wrdy_oe_n = !(s_d.st == HBP_IDLE &&
                          (s_d.vec_drv || s_d.slv_drv || strobe));
        s_d.wrdy_o = !s_d.ready_mode;
    end

    // R17 active-low reset, constants only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
            s_q.st <= HBP_IDLE;
            s_q.cfg <= HBP_CFG_RST;
            s_q.vector <= HBP_VEC_RST;
            s_q.prev_str <= 1'b0;
            s_q.prev_as <= 1'b1;
            s_q.prev_ack <= 1'b1;
            s_q.ad_oe_n <= 1'b1;
            s_q.as_n <= 1'b1;
            s_q.uas_n <= 1'b1;
            s_q.ds_n <= 1'b1;
            s_q.rd_n <= 1'b1;
            s_q.wr_n <= 1'b1;
            s_q.ctl_oe_n <= 1'b1;
            s_q.sel_oe_n <= 1'b1;
            s_q.wrdy_o <= 1'b1;
            s_q.wrdy_oe_n <= 1'b1;
            s_q.req_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign hrdata = s_q.hrdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign rd_n_out = s_q.rd_n;
    assign wr_n_out = s_q.wr_n;
    assign ds_n_out = s_q.ds_n;
    assign rw_out = !s_q.dir;
    assign addr_latch_strobe_n_out = s_q.as_n;
    assign upper_addr_strobe_n = s_q.uas_n;
    assign ctl_oe_n = s_q.ctl_oe_n;
    // R01 select pins name the active channel
    assign core_select_pin_out = s_q.chan[0];
    assign channel_select_pin_out = s_q.chan[1];
    assign sel_oe_n = s_q.sel_oe_n;
    assign wait_ready_out = s_q.wrdy_o;
    assign wait_ready_oe_n = s_q.wrdy_oe_n;
    assign ad_out = s_q.ad_out;
    assign ad_oe_n = s_q.ad_oe_n;
    assign bus_request_out_n = s_q.req_n;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_grant_drive: assert property (!ctl_oe_n |-> !$past(gnt_s) || !$past(ctl_oe_n)) // R02
        else $error("master drive without grant");
    a_sel_names: assert property (!sel_oe_n |-> {channel_select_pin_out, core_select_pin_out}
        == {s_q.chan[1], s_q.chan[0]} && !bus_request_out_n) // R01
        else $error("select pins wrong while master");
    a_addr_low: assert property (!addr_latch_strobe_n_out |->
        ad_out == s_q.dma_addr[15:0] && !ad_oe_n) // R03
        else $error("low address not on bus");
    a_addr_high: assert property (!upper_addr_strobe_n |->
        ad_out == s_q.dma_addr[31:16] && addr_latch_strobe_n_out) // R04
        else $error("high address not on bus");
    a_slave_pins: assert property (s_q.st inside {HBP_IDLE, HBP_REQ} |-> ctl_oe_n && sel_oe_n) // R05
        else $error("strobes driven as slave");
    a_release_order: assert property ($rose(bus_request_out_n) |-> $past(ctl_oe_n, 1)
        && $past(sel_oe_n, 1) && ad_oe_n) // R22
        else $error("request dropped before release");
    a_mode_strobe: assert property ($rose(s_q.configured) |-> s_q.muxed == $past(s_q.as_seen)) // R06
        else $error("bus mode not from strobe history");
    a_cfg_ready: assert property ($rose(s_q.configured) |-> s_q.ready_mode == !$past(ch_s)) // R08
        else $error("ready mode not from channel select");
    a_vec_window: assert property (s_q.vec_drv && s_q.st == HBP_IDLE |->
        !ad_oe_n && ad_out == {s_q.vector, s_q.vector}) // R23
        else $error("vector not driven in acknowledge");
    a_dbl_first: assert property (ack_on && ack_type == HBP_ACK_DOUBLE && !s_q.ack_cnt
        && s_q.st == HBP_IDLE |=> !s_q.vec_drv) // R12
        else $error("first double pulse drove bus");
    a_ready_ack: assert property (s_q.ready_mode && !wait_ready_oe_n |-> !wait_ready_out) // R18
        else $error("ready mode ack not low");

    c_master: cover property (s_q.st == HBP_DATA ##1 s_q.st == HBP_REL);
    c_vector: cover property ($rose(s_q.vec_drv) && ack_type == HBP_ACK_DOUBLE);
    c_muxed: cover property ($rose(s_q.configured) && s_q.muxed);
endmodule
`default_nettype wire

/* File: hbp_far.sv */
// Far-side model: bus arbiter, slow byte memory and address latches.
`timescale 1ns/1ps
`default_nettype none
module hbp_far (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Device master pins
    input wire logic req_n,
    input wire logic oe_n,
    input wire logic as_n,
    input wire logic uas_n,
    input wire logic ds_n,
    input wire logic [15:0] ad,
    input wire logic [1:0] sel,
    // Arbiter, memory and latch outputs
    output logic gnt_n,
    output logic rdy,
    output logic [15:0] mem_ad,
    output logic [31:0] lat,
    output logic [1:0] sel_seen
);
    // Memory word; lanes differ so a wrong lane shows
    localparam logic [15:0] MEM = 16'hA55A;
    logic [1:0] dly_q;
    // Arbiter, ready delay and latches
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gnt_n <= 1'b1;
            dly_q <= 2'h0;
            lat <= 32'h0000_0000;
            sel_seen <= 2'h0;
        end else begin
            gnt_n <= req_n;
            // Slow memory: ack only after some strobe cycles
            dly_q <= ds_n ? 2'h0 : (dly_q == 2'h3 ? dly_q : dly_q + 2'h1);
            // each half caught by its own strobe
            if (!oe_n && !as_n) lat[15:0] <= ad;
            if (!oe_n && !uas_n) lat[31:16] <= ad;
            if (!oe_n) sel_seen <= sel;
        end
    end
    // byte strobes from data strobe and latched A0
    logic upper_byte_strobe_n, lower_byte_strobe_n;
    assign upper_byte_strobe_n = oe_n | ds_n | lat[0];
    assign lower_byte_strobe_n = oe_n | ds_n | !lat[0];
    // Pull-up on ready; memory word on a byte strobe, inverted word otherwise
    assign rdy = !(dly_q == 2'h3);
    assign mem_ad = (upper_byte_strobe_n && lower_byte_strobe_n) ? ~MEM : MEM;
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Testbench for the host bus port: AHB registers, host pins and DMA.
`timescale 1ns/1ps
`default_nettype none
module tb_top import hbp_pkg::*;;
    // Bus and host pin drive
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [1:0] htrans = 2'h0;
    logic [7:0] haddr = 8'h00;
    logic [31:0] hwdata = 32'h0000_0000, hrdata, rd, lat;
    logic h_ce = 1, h_rd = 1, h_wr = 1, h_ack = 1, h_as = 1, h_cs = 1, h_ch = 1;
    logic [15:0] h_ad = 16'h0000, ad_out, ad_w, mem_ad;
    // Design outputs and resolved wires
    logic hreadyout, hresp, rd_n_out, wr_n_out, ds_n_out, rw_out, addr_latch_strobe_n_out;
    logic upper_addr_strobe_n, ctl_oe_n, core_select_pin_out, channel_select_pin_out;
    logic sel_oe_n, wait_ready_out, wait_ready_oe_n, ad_oe_n, bus_request_out_n, gnt_n, rdy;
    logic [1:0] sel_seen;
    int err_count = 0, n_compared = 0;
    // Enables, and slave drive as seen on the pins
    logic [31:0] oes, pins;
    assign oes = 32'({ctl_oe_n, sel_oe_n, ad_oe_n, bus_request_out_n});
    assign pins = 32'({ad_oe_n, wait_ready_oe_n, wait_ready_out, ad_out});
    // Pull-ups hold strobes high when nobody drives
    assign ad_w = !ad_oe_n ? ad_out : (!ctl_oe_n ? mem_ad : h_ad);
    hbp_port uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .ce_n(h_ce),
        .rd_n_in(ctl_oe_n ? h_rd : rd_n_out), .wr_n_in(ctl_oe_n ? h_wr : wr_n_out),
        .ds_n_in(ctl_oe_n | ds_n_out), .rw_in(ctl_oe_n | rw_out), .irq_ack_in_n(h_ack),
        .bus_grant_in_n(gnt_n), .addr_latch_strobe_n_in(ctl_oe_n ? h_as : addr_latch_strobe_n_out),
        // host select drivers off while the device owns the bus
        .core_select_pin_in(sel_oe_n ? h_cs : core_select_pin_out),
        .channel_select_pin_in(sel_oe_n ? h_ch : channel_select_pin_out),
        .wait_ready_in(wait_ready_oe_n ? rdy : wait_ready_out), .ad_in(ad_w),
        .rd_n_out, .wr_n_out, .ds_n_out, .rw_out, .addr_latch_strobe_n_out,
        .upper_addr_strobe_n, .ctl_oe_n, .core_select_pin_out, .channel_select_pin_out,
        .sel_oe_n, .wait_ready_out, .wait_ready_oe_n, .ad_out, .ad_oe_n, .bus_request_out_n);
    hbp_far far (.hclk, .hresetn, .req_n(bus_request_out_n), .oe_n(ctl_oe_n),
        .as_n(addr_latch_strobe_n_out), .uas_n(upper_addr_strobe_n), .ds_n(ds_n_out),
        .ad(ad_out), .sel({channel_select_pin_out, core_select_pin_out}), .gnt_n, .rdy,
        .mem_ad, .lat, .sel_seen);
    // Free-running 50 MHz clock
    initial begin
        forever #10 hclk = ~hclk;
    end
    // Compare and count
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One AHB single transfer; the slave may stretch either phase
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Host pin access held long enough for the sync pipes
    task hpin(input logic cs, input logic ch, input logic ack, input logic rdn, input logic [15:0] d);
        h_ce <= 1'b0;
        h_cs <= cs;
        h_ch <= ch;
        h_ack <= ack;
        h_rd <= rdn;
        h_wr <= ~rdn;
        h_ad <= d;
        repeat (6) @(posedge hclk);
    endtask
    task hrel;
        h_rd <= 1'b1;
        h_wr <= 1'b1;
        h_ack <= 1'b1;
        repeat (6) @(posedge hclk);
        h_ce <= 1'b1;
        @(posedge hclk);
    endtask
    // Address strobe pulse, chip enable left high
    task asp(input logic [15:0] d);
        h_ad <= d;
        h_as <= 1'b0;
        repeat (4) @(posedge hclk);
        h_as <= 1'b1;
        repeat (4) @(posedge hclk);
    endtask
    // One acknowledge pulse, pins checked while it is low
    task ackp(input logic [31:0] exp);
        h_ack <= 1'b0;
        repeat (6) @(posedge hclk);
        chk("ack pulse", pins, exp);
        h_ack <= 1'b1;
        repeat (6) @(posedge hclk);
    endtask
    // Poll status until the transfer is done; bounded
    task dma(input logic [31:0] a, input logic [31:0] c);
        int i;
        ahb(1'b1, HBP_OFS_ADDR, a);
        ahb(1'b1, HBP_OFS_CTRL, c);
        i = 0;
        do begin
            ahb(1'b0, HBP_OFS_STAT, 32'h0);
            i++;
        end while (rd[4] !== 1'b1 && i < 200);
        chk("dma status", rd, 32'h0000_C01C);
        chk("released", oes, 32'hF);
    endtask
    // Verdict, reached from the tests or the watchdog
    task test_done;
        $display("compared %0d errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Watchdog well beyond the expected run
    initial begin
        repeat (20000) @(posedge hclk);
        err_count++;
        test_done;
    end
    // Main sequence
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("slave pins", oes, 32'hF);
        ahb(1'b0, 8'h20, 32'h0);
        chk("unmapped", rd, 32'h0);
        // Config write: no strobe before it, channel select low
        hpin(1'b0, 1'b0, 1'b1, 1'b1, 16'h00C0);
        hrel;
        ahb(1'b0, HBP_OFS_SLV, 32'h0);
        chk("host access", rd, 32'h0000_C080);
        // A later write must not reconfigure
        hpin(1'b0, 1'b0, 1'b1, 1'b1, 16'h0086);
        hrel;
        ahb(1'b0, HBP_OFS_STAT, 32'h0);
        chk("config", rd, 32'h0000_C00C);
        // Device writes memory on receive channel A
        ahb(1'b1, HBP_OFS_WDATA, 32'h5A);
        dma(32'h1234_5679, 32'h0F);
        chk("latched addr", lat, 32'h1234_5679);
        chk("chan code", 32'(sel_seen), 32'h3);
        // Device reads an odd byte with swap set: upper lane
        dma(32'h0000_0001, 32'h05);
        ahb(1'b0, HBP_OFS_RDATA, 32'h0);
        chk("swapped byte", rd, 32'h0000_00A5);
        chk("chan code", 32'(sel_seen), 32'h1);
        // Status acknowledge with read strobe returns the vector
        ahb(1'b1, HBP_OFS_VEC, 32'h3C);
        hpin(1'b1, 1'b0, 1'b0, 1'b0, 16'h0000);
        chk("vector", pins, 32'h3C3C);
        hrel;
        chk("vector off", 32'(ad_oe_n), 32'h1);
        // Plain register read drives the read-back byte
        ahb(1'b1, HBP_OFS_SRD, 32'h77);
        hpin(1'b1, 1'b1, 1'b1, 1'b0, 16'h0000);
        chk("slave read", pins, 32'h7777);
        hrel;
        // Reset again: strobe first, wait mode, double pulses
        hresetn <= 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        asp(16'h0000);
        hpin(1'b0, 1'b1, 1'b1, 1'b1, 16'h0086);
        hrel;
        ahb(1'b0, HBP_OFS_STAT, 32'h0);
        chk("muxed config", rd, 32'h0000_8606);
        asp(16'h0006);
        hpin(1'b1, 1'b0, 1'b1, 1'b1, 16'h0011);
        hrel;
        ahb(1'b0, HBP_OFS_SLV, 32'h0);
        chk("muxed index", rd, 32'h0000_11C3);
        ahb(1'b1, HBP_OFS_VEC, 32'h69);
        ackp(32'h0007_0000);
        ackp(32'h0001_6969);
        test_done;
    end
endmodule
`default_nettype wire
